// file: rtl/frb_pkg.sv
// Package for the Ethernet register bank and shared DMA arbitration block
package frb_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFS_DMA_BUS_CONFIG = 12'h030;
  localparam logic [11:0] OFS_STATION_LOW = 12'hE00;
  localparam logic [11:0] OFS_STATION_HIGH = 12'hE04;
  localparam logic [11:0] OFS_HASH_UPPER = 12'hE08;
  localparam logic [11:0] OFS_HASH_LOWER = 12'hE0C;
  localparam logic [11:0] OFS_RX_RING_BASE = 12'hE10;
  localparam logic [11:0] OFS_TX_RING_BASE = 12'hE14;
  localparam logic [11:0] OFS_RX_BUF_LEN = 12'hE18;
  localparam logic [11:0] OFS_ETH_CONTROL = 12'hE40;
  localparam logic [11:0] OFS_IRQ_EVENT = 12'hE44;
  localparam logic [11:0] OFS_IRQ_MASK = 12'hE48;
  localparam logic [11:0] OFS_IRQ_VECTOR = 12'hE4C;
  localparam logic [11:0] OFS_RX_POLL = 12'hE50;
  localparam logic [11:0] OFS_TX_POLL = 12'hE54;
  localparam logic [11:0] OFS_MGMT_DATA = 12'hE80;
  localparam logic [11:0] OFS_MGMT_DIV = 12'hE84;
  localparam logic [11:0] OFS_FIFO_END = 12'hECC;
  localparam logic [11:0] OFS_RX_FIFO_BASE = 12'hED0;
  localparam logic [11:0] OFS_TX_FIFO_THR = 12'hEE4;
  localparam logic [11:0] OFS_TX_FIFO_BASE = 12'hEEC;
  localparam logic [11:0] OFS_FUNC_CODE = 12'hF34;
  localparam logic [11:0] OFS_RX_CONTROL = 12'hF44;
  localparam logic [11:0] OFS_RX_HASH_CTL = 12'hF48;
  localparam logic [11:0] OFS_TX_CONTROL = 12'hF84;
  localparam int NUM_GP_REGS = 22;

  // ==========================================================================
  // Field positions, little-endian bit numbers (big-endian bit n = 31 - n)
  localparam int FREEZE_EN_BIT = 14;   // big-endian bit 17
  localparam int ETH_PRIO_LSB = 2;     // big-endian bits 28-29
  localparam int PM_PRIO_LSB = 0;      // big-endian bits 30-31
  localparam logic [31:0] DMA_CFG_WMASK = 32'h0000400F;
  localparam logic [31:0] DMA_CFG_RESET = 32'h00000000;
  localparam logic [31:0] STATION_HIGH_WMASK = 32'hFFFF0000;
  localparam logic [31:0] RESP_UNMAPPED = 32'h00000000;

  // ==========================================================================
  // Fixed internal-bus levels of the other masters
  localparam logic [2:0] LVL_ICACHE = 3'h4;
  localparam logic [2:0] LVL_DCACHE = 3'h3;
  localparam logic [2:0] LVL_SYSIF = 3'h7;

  typedef enum logic [1:0] {FRB_OWN_NONE, FRB_OWN_CPM, FRB_OWN_ETH} frb_owner_t;

  // Request group of the two shared DMA engine users
  typedef struct packed {
    logic cpm_req;
    logic eth_req;
  } frb_dma_req_t;

  typedef struct packed {
    logic cpm_gnt;
    logic eth_gnt;
  } frb_dma_gnt_t;

  // Code 00..11 to priority level 6,5,2,1
  function automatic logic [2:0] frb_level(input logic [1:0] code);
    case (code)
      2'h0: frb_level = 3'h6;
      2'h1: frb_level = 3'h5;
      2'h2: frb_level = 3'h2;
      default: frb_level = 3'h1;
    endcase
  endfunction

endpackage

// file: rtl/frb_top.sv
// Ethernet register bank with shared DMA arbitration and bus priority logic
//
// Function
// - Simultaneous requests: processor module wins first
// - Both keep requesting: grants alternate
// - Freeze enabled: negate bus request while frozen
// - Freeze disabled: freeze input ignored
// - Ethernet priority code maps to 6,5,2,1
// - Processor module priority uses same code
// - Caches, interface unit fixed; DMA programmable
// - DMA config readable, writable, resets zero
// - One config register serves all channels
// - Registers are big-endian only
// - Low station word holds bytes 0-3
// - High station word holds bytes 4-5
// - Match 48-bit address, byte 0 first
// - Hash upper bit 0 is index 63
// - Hash lower bit 0 is index 31
// - Register set decoded at fixed offsets
// - FIFO end register is read-only
// - Function code register drives DMA transfers
`timescale 1ns/1ps
`default_nettype none

module frb_top #(
  parameter logic [31:0] FIFO_END_VALUE = 32'h00000600,
  parameter int CHANNELS = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Avalon-MM slave
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Shared DMA engine requests and grants
  input wire frb_pkg::frb_dma_req_t dma_req_i,
  output frb_pkg::frb_dma_gnt_t dma_gnt_o,
  // Freeze pin and internal bus mastership
  input wire logic freeze_i,
  input wire logic [CHANNELS-1:0] chan_req_i,
  output logic bus_request_o,
  input wire logic icache_req_i,
  input wire logic dcache_req_i,
  input wire logic sysif_req_i,
  output logic [3:0] bus_owner_o,
  output logic [2:0] eth_level_o,
  // Receive destination check
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_byte_valid_i,
  input wire logic rx_frame_start_i,
  output logic rx_addr_match_o,
  output logic rx_hash_hit_o,
  input wire logic [5:0] rx_hash_index_i,
  // Function code for Ethernet DMA
  output logic [31:0] func_code_o
);

  // Elaboration check: the channel vector is served by one shared config word,
  // so any other channel count has no meaning for the freeze and request logic
  if (CHANNELS != 16) begin : g_bad_channels
    $error("frb_top serves exactly 16 channels");
  end

  // ==========================================================================
  // Bus slave
  logic [31:0] dma_cfg_q;
  localparam int NUM_GP = frb_pkg::NUM_GP_REGS;
  logic [31:0] regs_q [NUM_GP];
  logic [31:0] wmask;
  logic rd_pend_q;
  logic hit;
  logic [4:0] idx;
  logic [31:0] rdata_d;

  // Byte enables to a bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
    end
  end

  // Map offset to general register slot
  always_comb begin
    hit = 1'b1;
    idx = 5'h00;
    case (avs_address_i)
      frb_pkg::OFS_STATION_LOW: idx = 5'h00;
      frb_pkg::OFS_STATION_HIGH: idx = 5'h01;
      frb_pkg::OFS_HASH_UPPER: idx = 5'h02;
      frb_pkg::OFS_HASH_LOWER: idx = 5'h03;
      frb_pkg::OFS_RX_RING_BASE: idx = 5'h04;
      frb_pkg::OFS_TX_RING_BASE: idx = 5'h05;
      frb_pkg::OFS_RX_BUF_LEN: idx = 5'h06;
      frb_pkg::OFS_ETH_CONTROL: idx = 5'h07;
      frb_pkg::OFS_IRQ_EVENT: idx = 5'h08;
      frb_pkg::OFS_IRQ_MASK: idx = 5'h09;
      frb_pkg::OFS_IRQ_VECTOR: idx = 5'h0A;
      frb_pkg::OFS_RX_POLL: idx = 5'h0B;
      frb_pkg::OFS_TX_POLL: idx = 5'h0C;
      frb_pkg::OFS_MGMT_DATA: idx = 5'h0D;
      frb_pkg::OFS_MGMT_DIV: idx = 5'h0E;
      frb_pkg::OFS_RX_FIFO_BASE: idx = 5'h0F;
      frb_pkg::OFS_TX_FIFO_BASE: idx = 5'h10;
      frb_pkg::OFS_FUNC_CODE: idx = 5'h11;
      frb_pkg::OFS_RX_CONTROL: idx = 5'h12;
      // Hash control, transmit control and threshold words are storage only
      frb_pkg::OFS_RX_HASH_CTL: idx = 5'h13;
      frb_pkg::OFS_TX_CONTROL: idx = 5'h14;
      frb_pkg::OFS_TX_FIFO_THR: idx = 5'h15;
      default: hit = 1'b0;
    endcase
  end

  // Read mux; words are stored as seen on the big-endian bus, no swapping
  always_comb begin
    rdata_d = frb_pkg::RESP_UNMAPPED;
    if (avs_address_i == frb_pkg::OFS_DMA_BUS_CONFIG) begin
      rdata_d = dma_cfg_q;
    end else if (avs_address_i == frb_pkg::OFS_FIFO_END) begin
      rdata_d = FIFO_END_VALUE;
    end else if (hit) begin
      // Unmapped offsets answer zero so a probe of the map sees no stale data
      rdata_d = regs_q[idx];
    end
  end

  // Writes complete at once, reads take one wait cycle to register data
  assign avs_waitrequest_o = avs_read_i & ~rd_pend_q;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_pend_q <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      rd_pend_q <= avs_read_i & ~rd_pend_q;
      if (avs_read_i & ~rd_pend_q) begin
        avs_readdata_o <= rdata_d;
      end
    end
  end

  // Configuration register, only FREEZE_ENABLE and the two priority fields hold state
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dma_cfg_q <= frb_pkg::DMA_CFG_RESET;
    end else if (avs_write_i && avs_address_i == frb_pkg::OFS_DMA_BUS_CONFIG) begin
      dma_cfg_q <= avs_writedata_i & wmask & frb_pkg::DMA_CFG_WMASK;
    end
  end

  // Address, hash and parameter words; undefined after reset so left unreset
  always_ff @(posedge clock_i) begin
    if (avs_write_i && hit) begin
      // Reserved low half forced to zero so a partial write leaves no unknown bits in that half
      if (idx == 5'h01) begin
        regs_q[idx] <= ((regs_q[idx] & ~wmask) | (avs_writedata_i & wmask)) & frb_pkg::STATION_HIGH_WMASK;
      end else begin
        regs_q[idx] <= (regs_q[idx] & ~wmask) | (avs_writedata_i & wmask);
      end
    end
  end

  // Only the function code word leaves the bank; station and hash words feed the receive logic, the rest are plain storage
  assign func_code_o = regs_q[17];

  // ==========================================================================
  // Shared DMA engine arbiter
  logic last_eth_q;
  logic cpm_pick;

  // Both asking: the side not served last wins; reset favours the processor module
  assign cpm_pick = dma_req_i.cpm_req & (~dma_req_i.eth_req | last_eth_q);
  assign dma_gnt_o.cpm_gnt = cpm_pick;
  assign dma_gnt_o.eth_gnt = dma_req_i.eth_req & ~cpm_pick;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_eth_q <= 1'b1;
    end else if (dma_req_i.cpm_req | dma_req_i.eth_req) begin
      last_eth_q <= ~cpm_pick;
    end
  end

  // ==========================================================================
  // Freeze pin synchroniser, three stages, agreement of last two
  logic frz_s1_q, frz_s2_q, frz_s3_q, frz_q;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frz_s1_q <= 1'b0;
      frz_s2_q <= 1'b0;
      frz_s3_q <= 1'b0;
      frz_q <= 1'b0;
    end else begin
      frz_s1_q <= freeze_i;
      frz_s2_q <= frz_s1_q;
      frz_s3_q <= frz_s2_q;
      if (frz_s2_q == frz_s3_q) begin
        frz_q <= frz_s3_q;
      end
    end
  end

  // Frozen only when enabled; request restarts once freeze drops
  logic frozen;
  assign frozen = frz_q & dma_cfg_q[frb_pkg::FREEZE_EN_BIT];
  assign bus_request_o = (|chan_req_i) & ~frozen;

  // ==========================================================================
  // Internal bus arbitration among four masters, highest level wins
  logic [2:0] dma_level;
  logic [2:0] best;
  logic [3:0] owner_d;

  assign dma_level = frb_pkg::frb_level(dma_cfg_q[frb_pkg::PM_PRIO_LSB +: 2]);
  assign eth_level_o = frb_pkg::frb_level(dma_cfg_q[frb_pkg::ETH_PRIO_LSB +: 2]);

  // Owner one-hot: 3 sysif, 2 icache, 1 dcache, 0 DMA; ties go to the fixed master
  always_comb begin
    owner_d = 4'h0;
    best = 3'h0;
    if (bus_request_o) begin
      owner_d = 4'h1;
      best = dma_level;
    end
    if (dcache_req_i && frb_pkg::LVL_DCACHE >= best) begin
      owner_d = 4'h2;
      best = frb_pkg::LVL_DCACHE;
    end
    if (icache_req_i && frb_pkg::LVL_ICACHE >= best) begin
      owner_d = 4'h4;
      best = frb_pkg::LVL_ICACHE;
    end
    if (sysif_req_i && frb_pkg::LVL_SYSIF >= best) begin
      owner_d = 4'h8;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_owner_o <= 4'h0;
    end else begin
      bus_owner_o <= owner_d;
    end
  end

  // ==========================================================================
  // Destination address compare, byte 0 first on the wire
  logic [2:0] byte_cnt_q;
  logic match_q;
  logic [7:0] want;
  logic [47:0] station;

  // Byte 0 is the top byte of the low word as seen big-endian
  assign station = {regs_q[0], regs_q[1][31:16]};
  always_comb begin
    want = station[47 - 8*byte_cnt_q -: 8];
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      byte_cnt_q <= 3'h0;
      match_q <= 1'b0;
      rx_addr_match_o <= 1'b0;
    end else if (rx_frame_start_i) begin
      byte_cnt_q <= 3'h0;
      match_q <= 1'b1;
      rx_addr_match_o <= 1'b0;
    end else if (rx_byte_valid_i && byte_cnt_q < 3'h6) begin
      byte_cnt_q <= byte_cnt_q + 3'h1;
      match_q <= match_q & (rx_byte_i == want);
      if (byte_cnt_q == 3'h5) begin
        rx_addr_match_o <= match_q & (rx_byte_i == want);
      end
    end
  end

  // Hash lookup: index 63 is upper bit 0 (MSB big-endian), index 0 is lower bit 31
  logic [63:0] hash_vec;
  assign hash_vec = {regs_q[2], regs_q[3]};

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_hash_hit_o <= 1'b0;
    end else begin
      rx_hash_hit_o <= hash_vec[rx_hash_index_i];
    end
  end

  // ==========================================================================
  // Checks
  // Assertion helper: no shared engine request seen since reset, so the
  // first simultaneous request can be told apart from later ones
  logic req_seen_q;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_seen_q <= 1'b0;
    end else if (dma_req_i.cpm_req | dma_req_i.eth_req) begin
      req_seen_q <= 1'b1;
    end
  end

  // Shared engine arbiter
  chk_first_cpm_wins: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (dma_req_i.cpm_req && dma_req_i.eth_req && !req_seen_q) |-> dma_gnt_o.cpm_gnt)
    else $error("first grant not to processor module");
  chk_grant_alternate: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (dma_req_i.cpm_req && dma_req_i.eth_req) ##1 (dma_req_i.cpm_req && dma_req_i.eth_req)
    |-> dma_gnt_o.cpm_gnt != $past(dma_gnt_o.cpm_gnt)) else $error("grants did not alternate");
  chk_lone_request: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (dma_req_i.eth_req && !dma_req_i.cpm_req) |-> dma_gnt_o.eth_gnt) else $error("lone request not granted");
  chk_cpm_lone: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (dma_req_i.cpm_req && !dma_req_i.eth_req) |-> dma_gnt_o.cpm_gnt) else $error("lone module request not granted");
  chk_grant_onehot: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !(dma_gnt_o.cpm_gnt && dma_gnt_o.eth_gnt)) else $error("both requesters granted");

  // Freeze; five samples cover the three flops and the agreement stage
  chk_freeze_blocks: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (dma_cfg_q[frb_pkg::FREEZE_EN_BIT] && freeze_i) [*5] |-> !bus_request_o) else $error("request while frozen");
  chk_freeze_release: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (!freeze_i) [*5] ##0 dma_cfg_q[frb_pkg::FREEZE_EN_BIT] |-> bus_request_o == (|chan_req_i))
    else $error("request not restored after freeze");
  chk_freeze_ignored: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !dma_cfg_q[frb_pkg::FREEZE_EN_BIT] |-> bus_request_o == (|chan_req_i)) else $error("freeze not ignored");

  // Bus priority levels
  chk_eth_level_map: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    eth_level_o == ((dma_cfg_q[3:2] == 2'h0) ? 3'h6 : (dma_cfg_q[3:2] == 2'h1) ? 3'h5 :
                    (dma_cfg_q[3:2] == 2'h2) ? 3'h2 : 3'h1)) else $error("ethernet level wrong");

  // Register bank and internal bus owner
  chk_cfg_write: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (avs_write_i && avs_address_i == frb_pkg::OFS_DMA_BUS_CONFIG && avs_byteenable_i == 4'hF)
    |=> dma_cfg_q == ($past(avs_writedata_i) & frb_pkg::DMA_CFG_WMASK)) else $error("config write lost");
  chk_fifo_end_ro: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (avs_read_i && !avs_waitrequest_o && $past(avs_address_i) == frb_pkg::OFS_FIFO_END && avs_address_i ==
     frb_pkg::OFS_FIFO_END) |-> avs_readdata_o == FIFO_END_VALUE) else $error("fifo end changed");
  chk_sysif_wins: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    sysif_req_i |=> bus_owner_o == 4'h8) else $error("fixed master lost");
  chk_dma_level_top: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (bus_request_o && dma_cfg_q[frb_pkg::PM_PRIO_LSB +: 2] == 2'h0 && !sysif_req_i) |=> bus_owner_o == 4'h1)
    else $error("dma at level 6 lost the bus");
  chk_owner_idle: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (!bus_request_o && !icache_req_i && !dcache_req_i && !sysif_req_i) |=> bus_owner_o == 4'h0) else $error("idle owner");
  chk_station_high: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (avs_write_i && avs_address_i == frb_pkg::OFS_STATION_HIGH) |=> regs_q[1][15:0] == 16'h0000)
    else $error("reserved station bits not zero");
  chk_func_code: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (avs_write_i && avs_address_i == frb_pkg::OFS_FUNC_CODE && avs_byteenable_i == 4'hF)
    |=> func_code_o == $past(avs_writedata_i)) else $error("function code not updated");
  chk_read_wait: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    $rose(avs_read_i) |-> avs_waitrequest_o) else $error("read answered without wait cycle");

  // Main scenarios
  cov_both_request: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    dma_req_i.cpm_req && dma_req_i.eth_req ##1 dma_req_i.cpm_req && dma_req_i.eth_req);
  cov_frozen: cover property (@(posedge clock_i) disable iff (!arst_n_i) frozen && (|chan_req_i));
  cov_addr_match: cover property (@(posedge clock_i) disable iff (!arst_n_i) rx_addr_match_o);
  cov_eth_wins: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    dma_gnt_o.eth_gnt && dma_req_i.cpm_req);
  cov_hash_hit: cover property (@(posedge clock_i) disable iff (!arst_n_i) rx_hash_hit_o);

endmodule

`default_nettype wire

// file: tb/frb_partner.sv
// Partner model of the masters that request the shared DMA engine and the internal bus
`timescale 1ns/1ps
`default_nettype none

module frb_partner (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Bench control: cpm, eth, channels, icache, dcache, sysif
  input wire logic [5:0] want_i,
  // Requests toward the block
  output var frb_pkg::frb_dma_req_t dma_req_o,
  output logic [15:0] chan_req_o,
  output logic icache_req_o,
  output logic dcache_req_o,
  output logic sysif_req_o
);
  // ==========================================================================
  // Requesters
  // Requests are levels held from one edge to the next; a requester that keeps
  // wanting the engine never drops out between grants, as a real one would not
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dma_req_o <= 2'h0;
      chan_req_o <= 16'h0000;
      icache_req_o <= 1'b0;
      dcache_req_o <= 1'b0;
      sysif_req_o <= 1'b0;
    end else begin
      dma_req_o.cpm_req <= want_i[5];
      dma_req_o.eth_req <= want_i[4];
      chan_req_o <= want_i[3] ? 16'h8001 : 16'h0000;  // Both end channels
      icache_req_o <= want_i[2];
      dcache_req_o <= want_i[1];
      sysif_req_o <= want_i[0];
    end
  end
endmodule
`default_nettype wire

// file: tb/frb_top_tb_top.sv
// Self-checking testbench for the Ethernet register bank and DMA arbitration block
`timescale 1ns/1ps
`default_nettype none

module frb_top_tb_top;
  // ==========================================================================
  // Signals
  logic clock_i, arst_n_i, avs_read_i, avs_write_i, freeze_i;
  logic [11:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, func_code_o, rd;
  logic avs_waitrequest_o, bus_request_o, icache_req_i, dcache_req_i, sysif_req_i;
  frb_pkg::frb_dma_req_t dma_req_i;
  frb_pkg::frb_dma_gnt_t dma_gnt_o;
  logic [15:0] chan_req_i;
  logic [3:0] bus_owner_o;
  logic [2:0] eth_level_o;
  logic [7:0] rx_byte_i;
  logic rx_byte_valid_i, rx_frame_start_i, rx_addr_match_o, rx_hash_hit_o;
  logic [5:0] rx_hash_index_i, want;
  logic [2:0] lvl [4] = '{3'h6, 3'h5, 3'h2, 3'h1};
  int hidx [4] = '{63, 0, 32, 31};
  int error_cnt, check_count, cycles;

  frb_top #(.FIFO_END_VALUE(32'h00000600), .CHANNELS(16)) i_frb_top (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(4'hF), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .dma_req_i(dma_req_i),
    .dma_gnt_o(dma_gnt_o), .freeze_i(freeze_i), .chan_req_i(chan_req_i), .bus_request_o(bus_request_o),
    .icache_req_i(icache_req_i), .dcache_req_i(dcache_req_i), .sysif_req_i(sysif_req_i),
    .bus_owner_o(bus_owner_o), .eth_level_o(eth_level_o), .rx_byte_i(rx_byte_i),
    .rx_byte_valid_i(rx_byte_valid_i), .rx_frame_start_i(rx_frame_start_i), .rx_addr_match_o(rx_addr_match_o),
    .rx_hash_hit_o(rx_hash_hit_o), .rx_hash_index_i(rx_hash_index_i), .func_code_o(func_code_o));

  frb_partner i_frb_partner (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .want_i(want), .dma_req_o(dma_req_i), .chan_req_o(chan_req_i),
    .icache_req_o(icache_req_i), .dcache_req_o(dcache_req_i), .sysif_req_o(sysif_req_i));

  // ==========================================================================
  // Clock and hang guard; the run needs well under a thousand cycles
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      close_out();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Bus write: request held until the edge that sees waitrequest low
  task automatic bw(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
    avs_write_i <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    chk(rd, exp);
  endtask
  // Destination field, first byte on the wire first
  task automatic frame(input logic [47:0] da);
    @(posedge clock_i);
    rx_frame_start_i <= 1'b1;
    @(posedge clock_i);
    rx_frame_start_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rx_byte_i <= da[47 - 8 * i -: 8];
      rx_byte_valid_i <= 1'b1;
      @(posedge clock_i);
    end
    rx_byte_valid_i <= 1'b0;
    cyc(3);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, freeze_i} = '0;
    {rx_byte_i, rx_byte_valid_i, rx_frame_start_i, rx_hash_index_i, want} = '0;
    arst_n_i = 1'b0;
    cyc(4);
    arst_n_i <= 1'b1;
    rchk(12'h030, 32'h00000000);
    bw(12'h030, 32'hFFFFFFFF);
    rchk(12'h030, 32'h0000400F);
    $display("config test done");
    // Both requesters at once, then keep requesting
    @(posedge clock_i);
    want <= 6'h30;
    cyc(1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      chk({30'h0, dma_gnt_o}, (i % 2) ? 32'h1 : 32'h2);
    end
    want <= 6'h10;
    cyc(3);
    chk({30'h0, dma_gnt_o}, 32'h1);
    want <= 6'h00;
    $display("arbiter test done");
    for (int c = 0; c < 4; c++) begin
      bw(12'h030, c << 2);
      cyc(1);
      chk({29'h0, eth_level_o}, {29'h0, lvl[c]});
    end
    // Internal bus owner against fixed levels 7, 4, 3
    bw(12'h030, 32'h00000000);
    want <= 6'h0C;
    cyc(5);
    chk({28'h0, bus_owner_o}, 32'h1);
    bw(12'h030, 32'h00000003);
    cyc(4);
    chk({28'h0, bus_owner_o}, 32'h4);
    want <= 6'h09;
    cyc(5);
    chk({28'h0, bus_owner_o}, 32'h8);
    want <= 6'h06;
    cyc(5);
    chk({28'h0, bus_owner_o}, 32'h4);
    $display("priority test done");
    bw(12'h030, 32'h00004000);
    want <= 6'h08;
    cyc(4);
    chk({31'h0, bus_request_o}, 32'h1);
    freeze_i <= 1'b1;
    cyc(8);
    chk({31'h0, bus_request_o}, 32'h0);
    freeze_i <= 1'b0;
    cyc(8);
    chk({31'h0, bus_request_o}, 32'h1);
    bw(12'h030, 32'h00000000);
    freeze_i <= 1'b1;
    cyc(8);
    chk({31'h0, bus_request_o}, 32'h1);
    freeze_i <= 1'b0;
    want <= 6'h00;
    $display("freeze test done");
    // Address tables are loaded before any frame arrives
    bw(12'hE00, 32'hA1B2C3D4);
    bw(12'hE04, 32'hE5F6ABCD);
    rchk(12'hE00, 32'hA1B2C3D4);
    rchk(12'hE04, 32'hE5F60000);
    frame(48'hA1B2C3D4E5F6);
    chk({31'h0, rx_addr_match_o}, 32'h1);
    frame(48'hA1B2C3D4F6E5);
    chk({31'h0, rx_addr_match_o}, 32'h0);
    bw(12'hE08, 32'h80000000);
    bw(12'hE0C, 32'h00000001);
    for (int i = 0; i < 4; i++) begin
      rx_hash_index_i <= hidx[i][5:0];
      cyc(3);
      chk({31'h0, rx_hash_hit_o}, (i < 2) ? 32'h1 : 32'h0);
    end
    $display("receive test done");
    rchk(12'hECC, 32'h00000600);
    bw(12'hECC, 32'hFFFFFFFF);
    rchk(12'hECC, 32'h00000600);
    bw(12'hF34, 32'h00001234);
    rchk(12'hF34, 32'h00001234);
    chk(func_code_o, 32'h00001234);
    bw(12'hE40, 32'h00000006);
    rchk(12'hE40, 32'h00000006);
    bw(12'hF44, 32'h0000005A);
    rchk(12'hF44, 32'h0000005A);
    bw(12'hF84, 32'h00000011);
    rchk(12'hF84, 32'h00000011);
    rchk(12'h100, 32'h00000000);
    $display("map test done");
    close_out();
  end
endmodule
`default_nettype wire
